// *** rtl/smd_params.svh ***
`ifndef SMD_PARAMS_SVH
`define SMD_PARAMS_SVH
`define SMD_ADDR_W        24
`define SMD_EXT_LO_END    24'h007fff
`define SMD_RSV_DS_BEG    24'h008000
`define SMD_RSV_DS_END    24'h009fff
`define SMD_DATA_SRAM_BEG     24'h00a000
`define SMD_DATA_SRAM_END     24'h00dfff
`define SMD_AUX_BEG       24'h00e000
`define SMD_AUX_END       24'h00efff
`define SMD_ECA_BEG       24'h00f000
`define SMD_ECA_END       24'h00f1ff
`define SMD_RSV_DP_BEG    24'h00f200
`define SMD_RSV_DP_END    24'h00f5ff
`define SMD_DUAL_PORT_RAM_BEG     24'h00f600
`define SMD_DUAL_PORT_RAM_END     24'h00fdff
`define SMD_DUAL_PORT_RAM_BIT_BEG 24'h00fd00
`define SMD_PCA_BEG       24'h00fe00
`define SMD_PCA_END       24'h00ffff
`define SMD_EXT_HI_BEG    24'h010000
`define SMD_EXT_HI_END    24'h1fffff
`define SMD_CAN_BEG       24'h200000
`define SMD_CAN_END       24'h203fff
`define SMD_SCU_BEG       24'h204000
`define SMD_SCU_END       24'h205fff
`define SMD_RSV_A_BEG     24'h206000
`define SMD_RSV_A_END     24'h207fff
`define SMD_ALT_BEG       24'h208000
`define SMD_ALT_END       24'h20bfff
`define SMD_RSV_B_BEG     24'h20c000
`define SMD_RSV_B_END     24'h20ffff
`define SMD_XIO_BEG       24'h210000
`define SMD_XIO_END       24'h3fffff
`define SMD_FLR_BEG       24'hc0f000
`define SMD_FLR_END       24'hc0ffff
`define SMD_ALT_OFS       24'h008000
`define SMD_ALT_CAN_END   24'h209fff
`define SMD_ALT_SCU_BEG   24'h20a000
`define SMD_ALT_SCU_OFS   24'h006000
`define SMD_GPR_BYTES     32
`define SMD_SECT_W        12
`define SMD_BLK_W         5
`define SMD_PROGRAM_SRAM_BEG     24'he00000
`define SMD_PROGRAM_SRAM_END     24'he07fff
`define SMD_SECT_SH       12
`define SMD_BLK_SH        7
`endif

// *** rtl/smd_pkg.sv ***
package smd_pkg;
    typedef enum logic [3:0] {
        SMD_T_NONE, SMD_T_EXT, SMD_T_DATA_SRAM, SMD_T_AUX, SMD_T_ECA, SMD_T_DUAL_PORT_RAM,
        SMD_T_PCA, SMD_T_CAN, SMD_T_SCU, SMD_T_FLASH_RSV, SMD_T_PROGRAM_SRAM
    } smd_target_t;
endpackage

// *** rtl/smd_mem_guard.sv ***
`timescale 1ns/10ps
`default_nettype none
module smd_mem_guard #(
    parameter int DW = 16
) (
    input  wire logic          clock,
    input  wire logic          nrst,
    input  wire logic          par_en,
    input  wire logic          ecc_en,
    input  wire logic          rd_vld,
    input  wire logic [DW-1:0] rd_data,
    input  wire logic [DW-1:0] rd_flip,
    input  wire logic          rd_par,
    output logic      [DW-1:0] fix_data_r,
    output logic               err_det_r,
    output logic               err_fix_r
);
    // flip marks the one bit the syndrome decoder points at
    wire logic          par_bad = rd_vld & ((^rd_data) ^ rd_par);
    wire logic          one_bit = (rd_flip != '0) && ((rd_flip & (rd_flip - 1'b1)) == '0);
    wire logic          can_fix = ecc_en & par_bad & one_bit;
    wire logic [DW-1:0] fixed   = can_fix ? (rd_data ^ rd_flip) : rd_data;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            fix_data_r <= '0;
            err_det_r  <= 1'b0;
            err_fix_r  <= 1'b0;
        end else begin
            fix_data_r <= fixed;
            err_det_r  <= par_bad & (par_en | ecc_en);
            err_fix_r  <= can_fix;
        end
    end
endmodule
`default_nettype wire

// *** rtl/smd_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "smd_params.svh"
// How it works
// - 00a000-00dfff selects the data sram.
// - 00f600-00fdff selects the dual port ram.
// - top 256 dual port bytes and register-bank words are bit addressable.
// - control areas at 00fe00-00ffff and 00f000-00f1ff.
// - can at 200000, serial at 204000, mirrored at 208000.
// - c0f000-c0ffff is reserved flash, flagged separately.
// - 000000-007fff and 010000-1fffff go to the external bus.
// - external io accesses disable pipeline optimisations.
// - writes into the protected program sram region are blocked.
// - flash sector and 128-byte block indices are reported.
// - parity detects, ecc detects and corrects single-bit errors.
// - 00e000-00efff selects the auxiliary register area.
module smd_decoder
    import smd_pkg::*;
#(
    parameter int AW = `SMD_ADDR_W,
    parameter int DW = 16
) (
    input  wire logic          clock,
    input  wire logic          nrst,
    input  wire logic          req,
    input  wire logic          wr,
    input  wire logic [AW-1:0] addr,
    input  wire logic [AW-1:0] gpr_base,
    input  wire logic [AW-1:0] program_sram_wp_size,
    input  wire logic          par_en,
    input  wire logic          ecc_en,
    input  wire logic          rd_vld,
    input  wire logic [DW-1:0] rd_data,
    input  wire logic [DW-1:0] rd_flip,
    input  wire logic          rd_par,
    output smd_target_t        target_r,
    output logic               sel_data_sram_r,
    output logic               sel_dual_port_ram_r,
    output logic               sel_aux_area_r,
    output logic               sel_ext_ctrl_area_r,
    output logic               sel_pri_ctrl_area_r,
    output logic               sel_can_r,
    output logic               sel_serial_r,
    output logic               sel_ext_bus_r,
    output logic               sel_program_sram_r,
    output logic               bit_addr_ok_r,
    output logic               ext_io_r,
    output logic               flash_rsv_r,
    output logic               reserved_r,
    output logic               wr_blocked_r,
    output logic [AW-1:0]      local_addr_r,
    output logic [11:0]        flash_sector_r,
    output logic [4:0]         flash_block_r,
    output logic [DW-1:0]      fix_data_r,
    output logic               err_det_r,
    output logic               err_fix_r
);
    // =====================================
    // range helper
    function automatic logic in_rng(input logic [AW-1:0] a, input logic [AW-1:0] lo,
                                    input logic [AW-1:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // =====================================
    // address decode
    wire logic hit_ext_lo = in_rng(addr, '0, `SMD_EXT_LO_END);
    wire logic hit_ext_hi = in_rng(addr, `SMD_EXT_HI_BEG, `SMD_EXT_HI_END);
    wire logic hit_ds     = in_rng(addr, `SMD_DATA_SRAM_BEG, `SMD_DATA_SRAM_END);
    wire logic hit_aux    = in_rng(addr, `SMD_AUX_BEG, `SMD_AUX_END);
    wire logic hit_eca    = in_rng(addr, `SMD_ECA_BEG, `SMD_ECA_END);
    wire logic hit_dp     = in_rng(addr, `SMD_DUAL_PORT_RAM_BEG, `SMD_DUAL_PORT_RAM_END);
    wire logic hit_pca    = in_rng(addr, `SMD_PCA_BEG, `SMD_PCA_END);
    wire logic hit_can    = in_rng(addr, `SMD_CAN_BEG, `SMD_CAN_END);
    wire logic hit_scu    = in_rng(addr, `SMD_SCU_BEG, `SMD_SCU_END);
    wire logic hit_alt    = in_rng(addr, `SMD_ALT_BEG, `SMD_ALT_END);
    wire logic hit_xio    = in_rng(addr, `SMD_XIO_BEG, `SMD_XIO_END);
    wire logic hit_flr    = in_rng(addr, `SMD_FLR_BEG, `SMD_FLR_END);
    wire logic hit_ps     = in_rng(addr, `SMD_PROGRAM_SRAM_BEG, `SMD_PROGRAM_SRAM_END);
    wire logic hit_rsv    = in_rng(addr, `SMD_RSV_DS_BEG, `SMD_RSV_DS_END)
                          | in_rng(addr, `SMD_RSV_DP_BEG, `SMD_RSV_DP_END)
                          | in_rng(addr, `SMD_RSV_A_BEG, `SMD_RSV_A_END)
                          | in_rng(addr, `SMD_RSV_B_BEG, `SMD_RSV_B_END);

    // mirror folds back onto the primary window so one page pointer reaches both;
    // only the first 8k of can regs fit beside the whole serial set in one page
    wire logic          alt_scu  = hit_alt & in_rng(addr, `SMD_ALT_SCU_BEG, `SMD_ALT_END);
    wire logic          alt_can  = hit_alt & ~alt_scu;
    wire logic [AW-1:0] alt_ofs  = alt_scu ? AW'(`SMD_ALT_SCU_OFS) : AW'(`SMD_ALT_OFS);
    wire logic [AW-1:0] alt_addr = addr - alt_ofs;

    // bank words are bit addressable wherever the register bank sits inside the dual port ram
    wire logic gpr_hit = hit_dp && (addr >= gpr_base) && (addr - gpr_base < AW'(`SMD_GPR_BYTES));
    wire logic bit_ok  = in_rng(addr, `SMD_DUAL_PORT_RAM_BIT_BEG, `SMD_DUAL_PORT_RAM_END) | gpr_hit
                       | hit_eca | hit_pca;

    // protected region grows down from the top of program sram
    wire logic [AW-1:0] wp_lo = AW'(`SMD_PROGRAM_SRAM_END) - program_sram_wp_size + 1'b1;
    wire logic wp_hit = hit_ps && (program_sram_wp_size != '0) && (addr >= wp_lo);
    wire logic blk    = req & wr & (wp_hit | hit_flr);

    smd_target_t tgt;
    assign tgt = hit_rsv  ? SMD_T_NONE :
                 hit_ds   ? SMD_T_DATA_SRAM :
                 hit_aux  ? SMD_T_AUX :
                 hit_eca  ? SMD_T_ECA :
                 hit_dp   ? SMD_T_DUAL_PORT_RAM :
                 hit_pca  ? SMD_T_PCA :
                 (hit_can | alt_can) ? SMD_T_CAN :
                 (hit_scu | alt_scu) ? SMD_T_SCU :
                 (hit_ext_lo | hit_ext_hi | hit_xio) ? SMD_T_EXT :
                 hit_flr  ? SMD_T_FLASH_RSV :
                 hit_ps   ? SMD_T_PROGRAM_SRAM : SMD_T_NONE;

    wire logic [AW-1:0] loc = alt_can | alt_scu ? alt_addr : addr;
    wire logic          go  = req & ~blk;

    // =====================================
    // next values, one per registered output except local_addr_r and wr_blocked_r
    smd_target_t target_nxt;
    assign target_nxt = req ? tgt : SMD_T_NONE;
    wire logic                   sel_ds_nxt    = go & (tgt == SMD_T_DATA_SRAM);
    wire logic                   sel_dp_nxt    = go & (tgt == SMD_T_DUAL_PORT_RAM);
    wire logic                   sel_aux_nxt   = go & (tgt == SMD_T_AUX);
    wire logic                   sel_eca_nxt   = go & (tgt == SMD_T_ECA);
    wire logic                   sel_pca_nxt   = go & (tgt == SMD_T_PCA);
    wire logic                   sel_can_nxt   = go & (tgt == SMD_T_CAN);
    wire logic                   sel_scu_nxt   = go & (tgt == SMD_T_SCU);
    wire logic                   sel_ext_nxt   = go & (tgt == SMD_T_EXT);
    wire logic                   sel_ps_nxt    = go & (tgt == SMD_T_PROGRAM_SRAM);
    wire logic                   bit_ok_nxt    = req & bit_ok;
    wire logic                   ext_io_nxt    = req & hit_xio;
    wire logic                   flash_rsv_nxt = req & hit_flr;
    wire logic                   reserved_nxt  = req & hit_rsv;
    wire logic [`SMD_SECT_W-1:0] sector_nxt    = addr[`SMD_SECT_SH +: `SMD_SECT_W];
    wire logic [`SMD_BLK_W-1:0]  block_nxt     = addr[`SMD_BLK_SH +: `SMD_BLK_W];

    // =====================================
    // registered target and local address
    always_ff @(posedge clock) begin
        if (!nrst) begin
            target_r     <= SMD_T_NONE;
            local_addr_r <= '0;
        end else begin
            target_r     <= target_nxt;
            local_addr_r <= loc;
        end
    end

    // =====================================
    // registered selects
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sel_data_sram_r     <= 1'b0;
            sel_dual_port_ram_r <= 1'b0;
            sel_aux_area_r      <= 1'b0;
            sel_ext_ctrl_area_r <= 1'b0;
            sel_pri_ctrl_area_r <= 1'b0;
            sel_can_r           <= 1'b0;
            sel_serial_r        <= 1'b0;
            sel_ext_bus_r       <= 1'b0;
            sel_program_sram_r  <= 1'b0;
        end else begin
            sel_data_sram_r     <= sel_ds_nxt;
            sel_dual_port_ram_r <= sel_dp_nxt;
            sel_aux_area_r      <= sel_aux_nxt;
            sel_ext_ctrl_area_r <= sel_eca_nxt;
            sel_pri_ctrl_area_r <= sel_pca_nxt;
            sel_can_r           <= sel_can_nxt;
            sel_serial_r        <= sel_scu_nxt;
            sel_ext_bus_r       <= sel_ext_nxt;
            sel_program_sram_r  <= sel_ps_nxt;
        end
    end

    // =====================================
    // registered flags
    // flags follow req even for blocked writes, so a trap handler sees the cause
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bit_addr_ok_r <= 1'b0;
            ext_io_r      <= 1'b0;
            flash_rsv_r   <= 1'b0;
            reserved_r    <= 1'b0;
            wr_blocked_r  <= 1'b0;
        end else begin
            bit_addr_ok_r <= bit_ok_nxt;
            ext_io_r      <= ext_io_nxt;
            flash_rsv_r   <= flash_rsv_nxt;
            reserved_r    <= reserved_nxt;
            wr_blocked_r  <= blk;
        end
    end

    // =====================================
    // registered flash indices
    always_ff @(posedge clock) begin
        if (!nrst) begin
            flash_sector_r <= '0;
            flash_block_r  <= '0;
        end else begin
            flash_sector_r <= sector_nxt;
            flash_block_r  <= block_nxt;
        end
    end

    // =====================================
    // memory content protection
    smd_mem_guard #(.DW(DW)) u_guard (
        .clock      (clock),
        .nrst       (nrst),
        .par_en     (par_en),
        .ecc_en     (ecc_en),
        .rd_vld     (rd_vld),
        .rd_data    (rd_data),
        .rd_flip    (rd_flip),
        .rd_par     (rd_par),
        .fix_data_r (fix_data_r),
        .err_det_r  (err_det_r),
        .err_fix_r  (err_fix_r)
    );
endmodule
`default_nettype wire

// *** sim/smd_decoder_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "smd_params.svh"
module smd_decoder_monitor #(
    parameter int AW = 24
) (
    input wire logic          clock,
    input wire logic          nrst,
    input wire logic          req,
    input wire logic          wr,
    input wire logic [AW-1:0] addr,
    input wire logic          sel_data_sram_r,
    input wire logic          sel_dual_port_ram_r,
    input wire logic          sel_aux_area_r,
    input wire logic          sel_ext_ctrl_area_r,
    input wire logic          sel_pri_ctrl_area_r,
    input wire logic          sel_can_r,
    input wire logic          sel_serial_r,
    input wire logic          sel_ext_bus_r,
    input wire logic          ext_io_r,
    input wire logic          flash_rsv_r,
    input wire logic          reserved_r
);
    // ==========
    // decode
    wire logic ds = req && addr inside {[`SMD_DATA_SRAM_BEG:`SMD_DATA_SRAM_END]};
    wire logic dp = req && addr inside {[`SMD_DUAL_PORT_RAM_BEG:`SMD_DUAL_PORT_RAM_END]};
    wire logic ctl = req && addr inside {[`SMD_ECA_BEG:`SMD_ECA_END], [`SMD_PCA_BEG:`SMD_PCA_END]};
    wire logic cn = req && addr inside {[`SMD_CAN_BEG:`SMD_CAN_END],
        [`SMD_ALT_BEG:`SMD_ALT_CAN_END]};
    wire logic sc = req && addr inside {[`SMD_SCU_BEG:`SMD_SCU_END],
        [`SMD_ALT_SCU_BEG:`SMD_ALT_END]};
    wire logic aux = req && addr inside {[`SMD_AUX_BEG:`SMD_AUX_END]};
    wire logic frd = req && !wr && addr inside {[`SMD_FLR_BEG:`SMD_FLR_END]};
    wire logic xio = req && addr inside {[`SMD_XIO_BEG:`SMD_XIO_END]};
    wire logic ext = req && addr inside {[0:`SMD_EXT_LO_END], [`SMD_EXT_HI_BEG:`SMD_EXT_HI_END]};
    wire logic rsv = req && addr inside {[`SMD_RSV_DS_BEG:`SMD_RSV_DS_END],
        [`SMD_RSV_DP_BEG:`SMD_RSV_DP_END], [`SMD_RSV_A_BEG:`SMD_RSV_A_END],
        [`SMD_RSV_B_BEG:`SMD_RSV_B_END]};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_rsv; rsv; endsequence
    sequence s_none; !sel_data_sram_r && !sel_dual_port_ram_r && !sel_ext_bus_r; endsequence
    // ==========
    // checks
    a_data_sram_sel: assert property (ds |=> sel_data_sram_r) else $error("data_sram not selected");
    a_dual_port_ram_sel: assert property (dp |=> sel_dual_port_ram_r) else $error("dual_port_ram missed");
    a_ctrl_areas: assert property (ctl |=> sel_pri_ctrl_area_r ^ sel_ext_ctrl_area_r)
        else $error("control area missed");
    a_can_mirror: assert property (cn |=> sel_can_r && !sel_serial_r) else $error("can missed");
    a_scu_mirror: assert property (sc |=> sel_serial_r && !sel_can_r)
        else $error("serial missed");
    a_ext_io: assert property (xio |=> ext_io_r && sel_ext_bus_r) else $error("io missed");
    a_ext_bus: assert property (ext |=> sel_ext_bus_r && !ext_io_r) else $error("ext missed");
    a_aux_sel: assert property (aux |=> sel_aux_area_r) else $error("aux missed");
    a_flash_rsv: assert property (frd |=> flash_rsv_r) else $error("flash reserve missed");
    a_rsv_flag: assert property (s_rsv |=> reserved_r ##0 s_none) else $error("reserved bad");
    a_idle_quiet: assert property (!req |=> !reserved_r ##0 s_none) else $error("idle sel");
endmodule
bind smd_decoder smd_decoder_monitor #(.AW(AW)) i_smd_decoder_monitor (.clock(clock), .nrst(nrst),
    .req(req), .wr(wr), .addr(addr), .sel_data_sram_r(sel_data_sram_r),
    .sel_dual_port_ram_r(sel_dual_port_ram_r), .sel_aux_area_r(sel_aux_area_r),
    .sel_ext_ctrl_area_r(sel_ext_ctrl_area_r), .sel_pri_ctrl_area_r(sel_pri_ctrl_area_r),
    .sel_can_r(sel_can_r), .sel_serial_r(sel_serial_r), .sel_ext_bus_r(sel_ext_bus_r),
    .ext_io_r(ext_io_r), .flash_rsv_r(flash_rsv_r), .reserved_r(reserved_r));
`default_nettype wire

// *** sim/smd_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module smd_cpu_model (
    input  wire logic        clock,
    output logic             req,
    output logic             wr,
    output logic [23:0]      addr
);
    initial begin
        req = 1'b0;
        wr = 1'b0;
        addr = 24'h000000;
    end
    // one access per cycle, launched off the sampling edge
    task automatic issue(input logic [23:0] a, input logic w);
        @(negedge clock);
        req = 1'b1;
        // no write data leaves the model, so spare control words only take zeros
        wr = w;
        addr = a;
    endtask
    // released address is scrambled so a stale value never looks valid
    task automatic idle();
        @(negedge clock);
        req = 1'b0;
        addr = ~addr;
    endtask
endmodule
`default_nettype wire

// *** sim/test_smd_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_smd_decoder
    import smd_pkg::*;
;
    logic clock = 1'b0, nrst = 1'b0, par_en = 1'b0, ecc_en = 1'b0, rd_vld = 1'b0, rd_par = 1'b0;
    logic req, wr;
    logic [23:0] addr, gpr_base = 24'h00f600, program_sram_wp_size = 24'h000100;
    logic [15:0] rd_data = 16'h0000, rd_flip = 16'h0000, d;
    smd_target_t target_r;
    logic bao, eio, frs, rsv, wbl, edet, efix, sps;
    logic [23:0] loc;
    logic [11:0] sect;
    logic [4:0] blk;
    logic [15:0] fixd;
    int miscompares = 0, checks = 0, seed = 87;
    logic [23:0] cor[$] = '{24'h007fff, 24'h008000, 24'h009fff, 24'h00a000, 24'h00dfff,
        24'h00e000, 24'h00efff, 24'h00f000, 24'h00f1ff, 24'h00f200, 24'h00f5ff, 24'h00f600,
        24'h00fcff, 24'h00fd00, 24'h00fdff, 24'h00fe00, 24'h00ffff, 24'h010000, 24'h1fffff,
        24'h200000, 24'h203fff, 24'h204000, 24'h205fff, 24'h206000, 24'h207fff, 24'h208000,
        24'h209fff, 24'h20a000, 24'h20bfff, 24'h20c000, 24'h20ffff, 24'h210000, 24'h3fffff,
        24'hc0f000, 24'hc0ffff,
        24'he00000, 24'he07eff, 24'he07f00};
    smd_cpu_model i_smd_cpu_model (.clock(clock), .req(req), .wr(wr), .addr(addr));
    smd_decoder i_smd_decoder (.clock(clock), .nrst(nrst), .req(req), .wr(wr), .addr(addr),
        .gpr_base(gpr_base), .program_sram_wp_size(program_sram_wp_size), .par_en(par_en), .ecc_en(ecc_en),
        .rd_vld(rd_vld), .rd_data(rd_data), .rd_flip(rd_flip), .rd_par(rd_par),
        .target_r(target_r), .sel_data_sram_r(), .sel_dual_port_ram_r(), .sel_aux_area_r(),
        .sel_ext_ctrl_area_r(), .sel_pri_ctrl_area_r(), .sel_can_r(), .sel_serial_r(),
        .sel_ext_bus_r(), .sel_program_sram_r(sps), .bit_addr_ok_r(bao), .ext_io_r(eio),
        .flash_rsv_r(frs), .reserved_r(rsv), .wr_blocked_r(wbl), .local_addr_r(loc),
        .flash_sector_r(sect), .flash_block_r(blk), .fix_data_r(fixd), .err_det_r(edet),
        .err_fix_r(efix));
    // ==========
    // expectations
    function automatic smd_target_t exp_tgt(logic [23:0] a);
        case (a) inside
            [24'h000000:24'h007fff], [24'h010000:24'h1fffff], [24'h210000:24'h3fffff]: return SMD_T_EXT;
            [24'h00a000:24'h00dfff]: return SMD_T_DATA_SRAM;
            [24'h00e000:24'h00efff]: return SMD_T_AUX;
            [24'h00f000:24'h00f1ff]: return SMD_T_ECA;
            [24'h00f600:24'h00fdff]: return SMD_T_DUAL_PORT_RAM;
            [24'h00fe00:24'h00ffff]: return SMD_T_PCA;
            [24'h200000:24'h203fff], [24'h208000:24'h209fff]: return SMD_T_CAN;
            [24'h204000:24'h205fff], [24'h20a000:24'h20bfff]: return SMD_T_SCU;
            [24'hc0f000:24'hc0ffff]: return SMD_T_FLASH_RSV;
            [24'he00000:24'he07fff]: return SMD_T_PROGRAM_SRAM;
            default: return SMD_T_NONE;
        endcase
    endfunction
    function automatic logic [23:0] exp_loc(logic [23:0] a);
        if (a inside {[24'h208000:24'h209fff]}) return a - 24'h008000;
        if (a inside {[24'h20a000:24'h20bfff]}) return a - 24'h006000;
        return a;
    endfunction
    function automatic logic exp_blk(logic [23:0] a, logic w);
        return w && (a inside {[24'hc0f000:24'hc0ffff]} ||
            a inside {[24'he08000 - program_sram_wp_size:24'he07fff]});
    endfunction
    task automatic check(logic [23:0] a, logic w);
        logic b;
        b = exp_blk(a, w);
        if (!b) `CHK(target_r, exp_tgt(a))
        `CHK(wbl, b)
        `CHK(rsv, exp_tgt(a) == SMD_T_NONE)
        `CHK(eio, a inside {[24'h210000:24'h3fffff]})
        `CHK({sect, blk}, a[23:7])
        `CHK(bao, a inside {[24'h00fd00:24'h00fdff], [24'h00f000:24'h00f1ff],
            [24'h00fe00:24'h00ffff], [gpr_base:gpr_base + 24'd31]})
        `CHK(loc, exp_loc(a))
        `CHK(frs, a inside {[24'hc0f000:24'hc0ffff]})
        `CHK(sps, !b && exp_tgt(a) == SMD_T_PROGRAM_SRAM)
    endtask
    task automatic complete_run();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        forever #2 clock = ~clock;
    end
    initial begin
        #40000;
        miscompares++;
        complete_run();
    end
    // ==========
    // sequence
    initial begin
        logic [23:0] pa, a;
        logic pw, w;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        for (int i = 0; i < 2 * cor.size() + 200; i++) begin
            a = i < 2 * cor.size() ? cor[i % cor.size()] : 24'($random(seed)) & 24'h3fffff;
            w = i < 2 * cor.size() ? i >= cor.size() : 1'($random(seed));
            if (i == 150) gpr_base = 24'h00f600 + {$random(seed)} % 24'h0700 & 24'hfffffe;
            i_smd_cpu_model.issue(a, w);
            if (i > 0) check(pa, pw);
            pa = a;
            pw = w;
        end
        i_smd_cpu_model.idle();
        check(pa, pw);
        for (int e = 0; e < 2; e++) begin
            d = 16'($random(seed));
            @(negedge clock);
            {par_en, ecc_en, rd_vld, rd_par, rd_flip, rd_data} = {1'b1, e[0], 1'b1, ^d, 16'h0010, d ^ 16'h0010};
            @(negedge clock);
            rd_vld = 1'b0;
            `CHK({edet, efix}, {1'b1, e[0]})
            `CHK(fixd, e[0] ? d : d ^ 16'h0010)
        end
        i_smd_cpu_model.issue(24'h008000, 1'b0);
        nrst = 1'b0;
        @(negedge clock);
        `CHK({target_r, rsv}, {SMD_T_NONE, 1'b0})
        complete_run();
    end
endmodule
`default_nettype wire
